// ===== design/lsst_ctrl.sv
`timescale 1ns/100ps
// ==========================================================================
// controller end: sensor clock, start pulse timing and pixel capture

module lsst_ctrl
    import lsst_pkg::*;
#(
    parameter int VIDEO_W = 12,
    parameter int HALF_CYC = SCLK_HALF_MIN
) (
    input wire logic clock, // system clock
    input wire logic arst_n, // asynchronous reset, active low
    lsst_link_if.ctrl link, // link to the sensor
    input wire logic enable, // run scans back to back while high
    input wire logic [SET_W-1:0] high_clocks, // start high time, sensor clocks
    input wire logic [SET_W-1:0] cycle_clocks, // start pulse cycle, sensor clocks
    output logic [VIDEO_W-1:0] pixel_data, // captured video sample
    output logic [STB_W-1:0] pixel_index, // index of pixel_data, 0 to 735
    output logic pixel_valid, // pulse per captured pixel
    output logic scan_done, // pulse with the last pixel of a scan
    output logic busy // high while a start cycle runs
);

    // half period never shorter than the 2 MHz limit allows
    localparam int HALF = (HALF_CYC > int'(SCLK_HALF_MIN)) ? HALF_CYC : int'(SCLK_HALF_MIN);
    localparam int DIV_W = $clog2(HALF + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF - 1);
    localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);

    typedef enum logic [1:0] {LSST_C_IDLE, LSST_C_HIGH, LSST_C_LOW} lsst_cstate_t;

    // ======================================================================
    // raise a setting to its least value
    function automatic lsst_set_t lsst_at_least(input lsst_set_t v, input lsst_set_t lo);
        return (v < lo) ? lo : v;
    endfunction

    // ======================================================================
    // sensor clock divider, equal halves
    logic [DIV_W-1:0] div_q, div_d;
    logic sclk_q, sclk_d;
    logic sclk_fall;

    // toggle every HALF system cycles: 50 percent duty, at most 2 MHz
    always_comb begin
        div_d = div_q + DIV_ONE;
        sclk_d = sclk_q;
        sclk_fall = 1'b0;
        if (div_q == DIV_LAST) begin
            div_d = '0;
            sclk_d = ~sclk_q;
            sclk_fall = sclk_q;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= '0;
            sclk_q <= 1'b0;
        end else begin
            div_q <= div_d;
            sclk_q <= sclk_d;
        end
    end

    // ======================================================================
    // start pulse sequencer, changes on sensor clock falls only
    lsst_cstate_t state_q, state_d;
    lsst_set_t ph_q, ph_d, hi_q, hi_d, lo_q, lo_d;
    logic st_q, st_d;
    logic busy_q, busy_d;
    logic st_fall;
    lsst_set_t hi_new, lo_new, rest;

    // settings taken at each cycle start, clamped to the link limits
    always_comb begin
        hi_new = lsst_at_least(high_clocks, SET_HIGH_MIN);
        rest = (cycle_clocks > hi_new) ? (cycle_clocks - hi_new) : '0;
        lo_new = lsst_at_least(rest, SET_LOW_MIN);
    end

    always_comb begin
        state_d = state_q;
        ph_d = ph_q;
        hi_d = hi_q;
        lo_d = lo_q;
        st_d = st_q;
        st_fall = 1'b0;
        if (sclk_fall) begin
            case (state_q)
                LSST_C_IDLE: begin
                    if (enable) begin
                        state_d = LSST_C_HIGH;
                        st_d = 1'b1;
                        ph_d = SET_ONE;
                        hi_d = hi_new;
                        lo_d = lo_new;
                    end
                end
                LSST_C_HIGH: begin
                    if (ph_q >= hi_q) begin
                        // high time is complete: integration ends, readout follows
                        state_d = LSST_C_LOW;
                        st_d = 1'b0;
                        st_fall = 1'b1;
                        ph_d = SET_ONE;
                    end else begin
                        ph_d = ph_q + SET_ONE;
                    end
                end
                LSST_C_LOW: begin
                    if (ph_q >= lo_q) begin
                        // low time complete; cycle is hi + lo, never below 18
                        if (enable) begin
                            state_d = LSST_C_HIGH;
                            st_d = 1'b1;
                            ph_d = SET_ONE;
                            hi_d = hi_new;
                            lo_d = lo_new;
                        end else begin
                            state_d = LSST_C_IDLE;
                        end
                    end else begin
                        ph_d = ph_q + SET_ONE;
                    end
                end
                default: begin
                    state_d = LSST_C_IDLE;
                    st_d = 1'b0;
                end
            endcase
        end
        busy_d = (state_d != LSST_C_IDLE);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= LSST_C_IDLE;
            ph_q <= '0;
            hi_q <= SET_HIGH_MIN;
            lo_q <= SET_LOW_MIN;
            st_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ph_q <= ph_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
            st_q <= st_d;
            busy_q <= busy_d;
        end
    end

    // ======================================================================
    // strobe and video synchronisers
    logic t1_q, t2_q, t3_q;
    logic [VIDEO_W-1:0] v1_q, v2_q;
    logic trig_rise;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            t1_q <= 1'b0;
            t2_q <= 1'b0;
            t3_q <= 1'b0;
            v1_q <= '0;
            v2_q <= '0;
        end else begin
            t1_q <= link.trig;
            t2_q <= t1_q;
            t3_q <= t2_q;
            v1_q <= link.video;
            v2_q <= v1_q;
        end
    end

    // video settles half a sensor period before the strobe edge
    assign trig_rise = t2_q & ~t3_q;

    // ======================================================================
    // pixel capture: count strobes from the start fall, keep 14 to 749
    lsst_stb_t stb_q, stb_d, stb_nx;
    lsst_stb_t idx_q, idx_d;
    logic [VIDEO_W-1:0] data_q, data_d;
    logic valid_q, valid_d, done_q, done_d;

    always_comb begin
        stb_d = stb_q;
        idx_d = idx_q;
        data_d = data_q;
        valid_d = 1'b0;
        done_d = 1'b0;
        stb_nx = (stb_q == STB_LAST) ? stb_q : (stb_q + STB_ONE);
        if (st_fall) begin
            stb_d = '0;
        end else if (trig_rise) begin
            stb_d = stb_nx;
            if (lsst_in_window(stb_nx) && stb_q != STB_LAST) begin
                data_d = v2_q;
                idx_d = stb_nx - STB_FIRST;
                valid_d = 1'b1;
                done_d = (stb_nx == STB_LAST);
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stb_q <= '0;
            idx_q <= '0;
            data_q <= '0;
            valid_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            stb_q <= stb_d;
            idx_q <= idx_d;
            data_q <= data_d;
            valid_q <= valid_d;
            done_q <= done_d;
        end
    end

    // ======================================================================
    // outputs, all from flops
    assign link.sensor_clk = sclk_q;
    assign link.scan_start_pulse = st_q;
    assign pixel_data = data_q;
    assign pixel_index = idx_q;
    assign pixel_valid = valid_q;
    assign scan_done = done_q;
    assign busy = busy_q;

endmodule

// ===== design/lsst_sensor.sv
`timescale 1ns/100ps
// ==========================================================================
// sensor end: timing generator, shift sequence and pixel strobe
module lsst_sensor
    import lsst_pkg::*;
#(
    parameter int VIDEO_W = 12
) (
    input wire logic clock, // system clock
    input wire logic arst_n, // asynchronous reset, active low
    lsst_link_if.sens link, // link to the controller
    output logic [STB_W-1:0] pix_addr, // pixel index asked of the array
    input wire logic [VIDEO_W-1:0] pix_data, // level of the addressed pixel
    output logic [SET_W-1:0] integ_clocks, // last integration, sensor clocks
    output logic integ_valid, // pulse when integ_clocks is updated
    output logic reading // high while pixels are shifted out
);

    typedef enum logic [0:0] {LSST_S_IDLE, LSST_S_READ} lsst_sstate_t;

    // ======================================================================
    // pin synchronisers
    logic c1_q, c2_q, c3_q, s1_q, s2_q;
    logic sclk_rise, sclk_fall;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            c1_q <= 1'b0;
            c2_q <= 1'b0;
            c3_q <= 1'b0;
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            c1_q <= link.sensor_clk;
            c2_q <= c1_q;
            c3_q <= c2_q;
            s1_q <= link.scan_start_pulse;
            s2_q <= s1_q;
        end
    end

    assign sclk_rise = c2_q & ~c3_q;
    assign sclk_fall = ~c2_q & c3_q;

    // ======================================================================
    // scan sequencer
    lsst_sstate_t state_q, state_d;
    logic st_prev_q, st_prev_d;
    lsst_set_t icnt_q, icnt_d, integ_q, integ_d;
    logic ival_q, ival_d, trig_q, trig_d;
    lsst_stb_t stb_q, stb_d, addr_q, addr_d;
    logic [VIDEO_W-1:0] video_q, video_d;

    // next values, stepped on sensor clock edges only
    always_comb begin
        state_d = state_q;
        st_prev_d = st_prev_q;
        icnt_d = icnt_q;
        integ_d = integ_q;
        ival_d = 1'b0;
        trig_d = trig_q;
        stb_d = stb_q;
        addr_d = addr_q;
        video_d = video_q;
        if (sclk_rise) begin
            st_prev_d = s2_q;
            if (s2_q) begin
                // start high: integrate, any readout in progress is dropped
                state_d = LSST_S_IDLE;
                trig_d = 1'b0;
                if (!st_prev_q) begin
                    icnt_d = SET_ONE;
                end else if (icnt_q != SET_ALL_ONES) begin
                    icnt_d = icnt_q + SET_ONE;
                end
            end else if (st_prev_q) begin
                // first rise after the fall: shifting starts, strobe one
                state_d = LSST_S_READ;
                stb_d = STB_ONE;
                trig_d = 1'b1;
                integ_d = icnt_q + SET_EXTRA;
                ival_d = 1'b1;
            end else if (state_q == LSST_S_READ) begin
                if (stb_q == STB_LAST) begin
                    state_d = LSST_S_IDLE;
                end else begin
                    stb_d = stb_q + STB_ONE;
                    trig_d = 1'b1;
                    if (stb_d >= STB_PRE) begin
                        addr_d = stb_d - STB_PRE; // pixel of the next strobe
                    end
                end
            end
        end else if (sclk_fall) begin
            trig_d = 1'b0;
            // load video half a period before the strobe that carries it
            if (state_q == LSST_S_READ && stb_q >= STB_PRE && stb_q < STB_LAST) begin
                video_d = pix_data;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= LSST_S_IDLE;
            st_prev_q <= 1'b0;
            icnt_q <= '0;
            integ_q <= '0;
            ival_q <= 1'b0;
            trig_q <= 1'b0;
            stb_q <= '0;
            addr_q <= '0;
            video_q <= '0;
        end else begin
            state_q <= state_d;
            st_prev_q <= st_prev_d;
            icnt_q <= icnt_d;
            integ_q <= integ_d;
            ival_q <= ival_d;
            trig_q <= trig_d;
            stb_q <= stb_d;
            addr_q <= addr_d;
            video_q <= video_d;
        end
    end

    // ======================================================================
    // outputs, all from flops
    assign link.trig = trig_q;
    assign link.video = video_q;
    assign pix_addr = addr_q;
    assign integ_clocks = integ_q;
    assign integ_valid = ival_q;
    assign reading = (state_q == LSST_S_READ);

endmodule

// ===== inc/lsst_link_if.sv
`timescale 1ns/100ps
// ==========================================================================
// sensor link: clock and start pulse out of the controller, video and strobe back
interface lsst_link_if #(
    parameter int VIDEO_W = 12
);
    logic sensor_clk; // sensor clock made by the controller
    logic scan_start_pulse; // start pulse, high sets integration
    logic [VIDEO_W-1:0] video; // digitised video level, one per strobe
    logic trig; // pixel strobe, video taken on its rising edge

    modport ctrl (
        output sensor_clk,
        output scan_start_pulse,
        input video,
        input trig
    );

    modport sens (
        input sensor_clk,
        input scan_start_pulse,
        output video,
        output trig
    );
endinterface

// ===== inc/lsst_pkg.sv
// ==========================================================================
// shared constants for the linear sensor scan link
package lsst_pkg;

    // ======================================================================
    // system clock and sensor clock limits
    localparam int unsigned SYS_CLK_HZ = 200_000_000; // system clock rate
    localparam int unsigned SCLK_MAX_HZ = 2_000_000; // fastest sensor clock
    localparam int unsigned DUTY_MIN_PCT = 45; // least high-time share
    localparam int unsigned DUTY_MAX_PCT = 55; // largest high-time share
    // half period of the sensor clock in system cycles, rounded up (least time)
    localparam int unsigned SCLK_HALF_MIN = (SYS_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);

    // ======================================================================
    // scan geometry and start pulse limits, in sensor clock periods
    localparam int unsigned PIXELS = 736; // pixels per scan
    localparam int unsigned ST_HIGH_MIN = 2; // least start pulse high time
    localparam int unsigned ST_LOW_MIN = 16; // least start pulse low time
    localparam int unsigned ST_CYCLE_MIN = 18; // least start pulse cycle
    localparam int unsigned INTEG_EXTRA = 6; // integration beyond high time
    localparam int unsigned FIRST_VALID_STROBE = 14; // strobe of pixel 0

    // ======================================================================
    // widths and typed constants
    localparam int unsigned STB_W = 10; // strobe counter width
    localparam int unsigned SET_W = 16; // start pulse setting width
    typedef logic [STB_W-1:0] lsst_stb_t;
    typedef logic [SET_W-1:0] lsst_set_t;
    localparam lsst_stb_t STB_ONE = 10'h001;
    localparam lsst_stb_t STB_FIRST = STB_W'(FIRST_VALID_STROBE);
    localparam lsst_stb_t STB_LAST = STB_W'(FIRST_VALID_STROBE + PIXELS - 1);
    localparam lsst_stb_t STB_PRE = STB_W'(FIRST_VALID_STROBE - 1);
    localparam lsst_set_t SET_ONE = 16'h0001;
    localparam lsst_set_t SET_HIGH_MIN = SET_W'(ST_HIGH_MIN);
    localparam lsst_set_t SET_LOW_MIN = SET_W'(ST_LOW_MIN);
    localparam lsst_set_t SET_EXTRA = SET_W'(INTEG_EXTRA);
    localparam lsst_set_t SET_ALL_ONES = 16'hffff;

    // ======================================================================
    // true while a strobe number carries a valid pixel
    function automatic logic lsst_in_window(input lsst_stb_t n);
        return (n >= STB_FIRST) && (n <= STB_LAST);
    endfunction

endpackage

// ===== verif/linear_sensor_scan_timing_test.sv
`timescale 1ns/100ps
// ==========================================================================
// a cut short scan then one full scan, checked at both user sides
module linear_sensor_scan_timing_test;
    import lsst_pkg::*;
    logic clock, arst_n, enable;
    logic [SET_W-1:0] high_clocks, cycle_clocks, integ_clocks;
    logic [STB_W-1:0] pix_addr, pixel_index;
    logic [11:0] pix_data, pixel_data;
    logic integ_valid, reading, pixel_valid, scan_done, busy;
    logic trig_last, st_last, clk_last;
    int bad_count, checks, cyc, strobes, hi_rises, pixels, n, falls, integs;

    lsst_link_if #(.VIDEO_W(12)) lsst_link_if_i ();

    lsst_ctrl #(.VIDEO_W(12)) lsst_ctrl_i (
        .clock(clock), .arst_n(arst_n), .link(lsst_link_if_i.ctrl), .enable(enable),
        .high_clocks(high_clocks), .cycle_clocks(cycle_clocks),
        .pixel_data(pixel_data), .pixel_index(pixel_index),
        .pixel_valid(pixel_valid), .scan_done(scan_done), .busy(busy));

    lsst_sensor #(.VIDEO_W(12)) lsst_sensor_i (
        .clock(clock), .arst_n(arst_n), .link(lsst_link_if_i.sens),
        .pix_addr(pix_addr), .pix_data(pix_data), .integ_clocks(integ_clocks),
        .integ_valid(integ_valid), .reading(reading));

    lsst_asserts #(.VIDEO_W(12)) lsst_asserts_i (
        .clock(clock), .arst_n(arst_n), .sensor_clk(lsst_link_if_i.sensor_clk),
        .scan_start_pulse(lsst_link_if_i.scan_start_pulse),
        .video(lsst_link_if_i.video), .trig(lsst_link_if_i.trig));

    // pixel array: each level is a fixed function of its address
    assign pix_data = {2'b10, pix_addr};

    // ======================================================================
    // shared compare and closing report
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (bad_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            final_report();
        end
    end

    // ======================================================================
    // link watcher: start high length, strobe count, first pixel on the wire
    always @(posedge clock) begin
        if (lsst_link_if_i.scan_start_pulse && lsst_link_if_i.sensor_clk && !clk_last) begin
            hi_rises++;
        end
        // per cycle: the short cycle is cut after 16 strobes by the next start
        if (st_last && !lsst_link_if_i.scan_start_pulse) begin
            check("start high clocks", hi_rises, (falls == 0) ? 2 : 3);
            check("strobes before start", strobes, (falls == 0) ? 0 : 16);
            check("pixels before start", pixels, (falls == 0) ? 0 : 3);
            falls++;
            hi_rises = 0;
            strobes = 0;
            pixels = 0;
        end
        if (lsst_link_if_i.trig && !trig_last) begin
            strobes++;
            if (strobes == 14) begin
                check("video at strobe 14", lsst_link_if_i.video, 12'h800);
                check("pix_addr at strobe 14", pix_addr, 1);
            end
        end
        trig_last = lsst_link_if_i.trig;
        st_last = lsst_link_if_i.scan_start_pulse;
        clk_last = lsst_link_if_i.sensor_clk;
    end

    // user side watcher: integration length and every captured pixel
    always @(posedge clock) begin
        if (integ_valid === 1'b1) begin
            check("integ_clocks", integ_clocks, (integs == 0) ? 16'h0008 : 16'h0009);
            integs++;
        end
        if (pixel_valid === 1'b1) begin
            check("pixel_index", pixel_index, pixels);
            check("pixel_data", pixel_data, {20'h0, 2'b10, 10'(pixels)});
            check("scan_done", scan_done, pixels == 735);
            pixels++;
        end
    end

    // ======================================================================
    // main sequence: an 18 clock cycle, then a 752 clock cycle with 3 high
    initial begin
        arst_n = 1'b0;
        enable = 1'b0;
        high_clocks = 16'h0002;
        cycle_clocks = 16'h0012;
        trig_last = 1'b0;
        st_last = 1'b0;
        clk_last = 1'b0;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        enable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (busy !== 1'b1 && n < 200);
        check("busy after enable", busy, 1'b1);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (falls < 1 && n < 400);
        // settings for the next cycle, taken when the short cycle ends
        high_clocks <= 16'h0003;
        cycle_clocks <= 16'h02f0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (lsst_link_if_i.scan_start_pulse !== 1'b1 && n < 2000);
        enable <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (scan_done !== 1'b1 && n < 80000);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (busy !== 1'b0 && n < 2000);
        repeat (200) @(posedge clock);
        check("pixels per scan", pixels, 736);
        check("strobes per scan", strobes, 749);
        check("reading after scan", reading, 1'b0);
        check("busy after scan", busy, 1'b0);
        check("start idle", lsst_link_if_i.scan_start_pulse, 1'b0);
        check("integrations", integs, 2);
        check("start falls", falls, 2);
        final_report();
    end
endmodule

// ===== verif/lsst_asserts.sv
`timescale 1ns/100ps
// ==========================================================================
// link checker: sensor clock shape, start pulse widths, strobe placement
module lsst_asserts
    import lsst_pkg::*;
#(
    parameter int VIDEO_W = 12,
    parameter int HALF_CYC = SCLK_HALF_MIN
) (
    input wire logic clock, // system clock
    input wire logic arst_n, // asynchronous reset, active low
    input wire logic sensor_clk, // sensor clock on the link
    input wire logic scan_start_pulse, // start pulse on the link
    input wire logic [VIDEO_W-1:0] video, // video word on the link
    input wire logic trig // pixel strobe on the link
);
    localparam int TRIG_LO = 50; // earliest strobe after start falls
    localparam int TRIG_HI = 60; // latest strobe after start falls
    logic clk_last_q, st_last_q, tr_last_q, clk_seen_q, st_seen_q;
    int unsigned clk_run_q, st_run_q, tr_gap_q;

    // ======================================================================
    // cycles since the last change of clock and start, and since the last strobe rise
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            clk_last_q <= 1'b0;
            st_last_q <= 1'b0;
            tr_last_q <= 1'b0;
            clk_seen_q <= 1'b0;
            st_seen_q <= 1'b0;
            clk_run_q <= 0;
            st_run_q <= 0;
            tr_gap_q <= 32'hffff_ffff;
        end else begin
            clk_last_q <= sensor_clk;
            st_last_q <= scan_start_pulse;
            tr_last_q <= trig;
            clk_seen_q <= clk_seen_q | (sensor_clk != clk_last_q);
            st_seen_q <= st_seen_q | (scan_start_pulse != st_last_q);
            clk_run_q <= (sensor_clk != clk_last_q) ? 1 : clk_run_q + 1;
            st_run_q <= (scan_start_pulse != st_last_q) ? 1 : st_run_q + 1;
            if (trig && !tr_last_q) begin
                tr_gap_q <= 1;
            end else if (tr_gap_q != 32'hffff_ffff) begin
                tr_gap_q <= tr_gap_q + 1;
            end
        end
    end

    // ======================================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_clk_half_period: assert property (
        (sensor_clk != clk_last_q) && clk_seen_q |-> clk_run_q == HALF_CYC)
        else $error("sensor clock half period wrong");
    a_start_clk_low: assert property (
        $changed(scan_start_pulse) |-> !sensor_clk)
        else $error("start pulse moved while sensor clock high");
    a_start_high_min: assert property (
        $fell(scan_start_pulse) |-> st_run_q >= ST_HIGH_MIN * 2 * HALF_CYC)
        else $error("start pulse high too short");
    a_start_low_min: assert property (
        $rose(scan_start_pulse) && st_seen_q |-> st_run_q >= ST_LOW_MIN * 2 * HALF_CYC)
        else $error("start pulse low too short");
    a_shift_after_fall: assert property (
        $fell(scan_start_pulse) |-> ##[TRIG_LO:TRIG_HI] $rose(trig))
        else $error("first strobe not at first clock rise after start fall");
    a_strobe_start_low: assert property (
        $rose(trig) |-> !scan_start_pulse && sensor_clk)
        else $error("strobe while start high or clock low");
    a_strobe_width_min: assert property (
        $rose(trig) |-> trig [*8])
        else $error("strobe too narrow");
    a_video_stable_strobe: assert property (
        $rose(trig) |-> $stable(video) ##1 $stable(video))
        else $error("video moving at strobe rise");
    a_strobe_spacing: assert property (
        trig && !tr_last_q |-> tr_gap_q >= 2 * HALF_CYC)
        else $error("strobes closer than one sensor period");

    // main scenarios reached
    c_start_fall: cover property ($fell(scan_start_pulse));
    c_strobe: cover property ($rose(trig));
    c_start_rise: cover property ($rose(scan_start_pulse) && st_seen_q);
endmodule
